// ===== design/dds_ctrl_if.sv
`timescale 1ns/1ps
interface dds_ctrl_if;
  logic update_pulse;
  logic ramp_reload;
  logic autoclr_freq;
  logic autoclr_phase;
  logic hold_freq;
  logic hold_phase;
  modport ctrl (output update_pulse, ramp_reload, autoclr_freq, autoclr_phase, hold_freq, hold_phase);
  modport core (input update_pulse, ramp_reload, autoclr_freq, autoclr_phase, hold_freq, hold_phase);
endinterface : dds_ctrl_if

// ===== design/dds_profile_and_control_regs.sv
`timescale 1ns/1ps
// Contract
// - Profile six and seven hold a 14-bit phase offset in top bytes; top bits reserved.
// - Profile six and seven hold a 48-bit tuning word in low six bytes.
// - In sync-input mode, loss of lock sets the read-only unlock flag, bit 24.
// - Unlock flag stays set after relock until main control is read back.
// - Ramp rate down-counter runs on sync clock, loaded at each sweep step.
// - Bit 23 clear reloads counter only at countdown end; set, update also reloads while sweep is enabled.
// - Bit 22 set makes each update clear the frequency accumulator one sync period.
// - After frequency auto-clear the sweep restarts from tuning word zero.
// - Bit 21 set makes each update clear the phase accumulator one sync period.
// - Bit 20 selects cosine when zero, sine when one.
// - Bit 19 set holds the frequency accumulator at zero.
// - Bit 18 set holds the phase accumulator at zero.
// - Bit 15 selects serial order: MSB first when zero, LSB first when one.
// - Writable control bits 23 to 15 reset to zero.
// - Sync clock timing accumulators and ramp counter is system clock divided by four.
// - In sync-input mode loss of lock is reported via the sticky flag only.
module dds_profile_and_control_regs (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Serial port
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  // Sync and lock status
  input wire logic i_sync_in_mode,
  input wire logic i_lock_lost,
  input wire logic i_io_update,
  // Sweep settings
  input wire logic i_sweep_en,
  input wire logic [15:0] i_ramp_rate,
  input wire logic [47:0] i_sweep_delta,
  input wire logic [47:0] i_tuning_word_zero,
  // Control and profile outputs
  output logic o_sine_sel,
  output logic o_lsb_first,
  output logic [13:0] o_phase_offset_six,
  output logic [47:0] o_tuning_word_six,
  output logic [13:0] o_phase_offset_seven,
  output logic [47:0] o_tuning_word_seven,
  // Accumulators
  output logic [47:0] o_freq_word,
  output logic [47:0] o_phase_acc
);
  typedef enum logic [1:0] {S_IDLE, S_INSTR, S_DATA, S_DONE} spi_state_t;

  spi_state_t state_r;
  logic sclk_q;
  logic rise;
  logic fall;
  logic upd_q;
  logic upd_pulse_r;
  logic [2:0] icnt_r;
  logic [7:0] instr_r;
  logic [7:0] ins_full;
  logic rd_r;
  logic [4:0] addr_r;
  logic [6:0] nbits_r;
  logic [6:0] bcnt_r;
  logic last;
  logic [63:0] sh_r;
  logic [63:0] sh_nxt;
  logic [63:0] wr_word;
  logic [63:0] rd_word;
  logic [63:0] rdw_r;
  logic wr_commit;
  logic rd_clear;
  logic unlock_r;
  logic lsb;
  logic [dds_regs_pkg::RAMP_RELOAD_BIT:dds_regs_pkg::LSB_FIRST_BIT] ctrl_r;

  dds_ctrl_if ctl ();

  function automatic logic [6:0] reg_bits(input logic [4:0] a);
    case (a)
      dds_regs_pkg::ADDR_MAIN_CTRL: reg_bits = dds_regs_pkg::CTRL_BITS;
      dds_regs_pkg::ADDR_PROFILE_SIX: reg_bits = dds_regs_pkg::PROFILE_BITS;
      dds_regs_pkg::ADDR_PROFILE_SEVEN: reg_bits = dds_regs_pkg::PROFILE_BITS;
      default: reg_bits = 7'h00;
    endcase
  endfunction : reg_bits

  // Bit k of an n-bit word in the current serial order
  function automatic logic pick(input logic [63:0] w, input logic [6:0] n, input logic [6:0] k, input logic l);
    logic [6:0] j;
    j = l ? k : (n - 7'h01 - k);
    pick = w[j[5:0]];
  endfunction : pick

  assign lsb = ctrl_r[dds_regs_pkg::LSB_FIRST_BIT];
  assign rise = i_sclk & ~sclk_q;
  assign fall = ~i_sclk & sclk_q;
  assign ins_full = lsb ? {i_sdio, instr_r[7:1]} : {instr_r[6:0], i_sdio};
  assign sh_nxt = lsb ? {i_sdio, sh_r[63:1]} : {sh_r[62:0], i_sdio};
  assign wr_word = lsb ? (sh_nxt >> (7'h40 - nbits_r)) : sh_nxt;
  assign last = (bcnt_r == nbits_r - 7'h01);
  // Only a complete word commits; a short frame is dropped
  assign wr_commit = rise && state_r == S_DATA && !rd_r && last;
  assign rd_clear = rise && state_r == S_DATA && rd_r && last && addr_r == dds_regs_pkg::ADDR_MAIN_CTRL;

  always_comb
  begin
    case (ins_full[4:0])
      dds_regs_pkg::ADDR_MAIN_CTRL: rd_word = {32'h00000000, 7'h00, unlock_r,
        ctrl_r[dds_regs_pkg::RAMP_RELOAD_BIT:dds_regs_pkg::HOLD_PHASE_BIT], 2'h0,
        ctrl_r[dds_regs_pkg::LSB_FIRST_BIT], 15'h0000};
      dds_regs_pkg::ADDR_PROFILE_SIX: rd_word = {2'h0, o_phase_offset_six, o_tuning_word_six};
      dds_regs_pkg::ADDR_PROFILE_SEVEN: rd_word = {2'h0, o_phase_offset_seven, o_tuning_word_seven};
      default: rd_word = 64'h0000000000000000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_q <= 1'b0;
      upd_q <= 1'b0;
      upd_pulse_r <= 1'b0;
    end
    else if (i_ce)
    begin
      sclk_q <= i_sclk;
      upd_q <= i_io_update;
      upd_pulse_r <= i_io_update & ~upd_q;
    end
  end

  // Serial frame sequencing; SCLK must stay low one cycle after CS falls
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= S_IDLE;
      icnt_r <= 3'h0;
      instr_r <= 8'h00;
      rd_r <= 1'b0;
      addr_r <= 5'h00;
      nbits_r <= 7'h00;
      bcnt_r <= 7'h00;
      sh_r <= 64'h0000000000000000;
      rdw_r <= 64'h0000000000000000;
    end
    else if (i_ce)
    begin
      if (i_cs_n)
        state_r <= S_IDLE;
      else
      begin
        case (state_r)
          S_IDLE:
          begin
            state_r <= S_INSTR;
            icnt_r <= 3'h0;
          end
          S_INSTR:
          begin
            if (rise)
            begin
              instr_r <= ins_full;
              icnt_r <= icnt_r + 3'h1;
              if (icnt_r == dds_regs_pkg::INSTR_LAST)
              begin
                rd_r <= ins_full[dds_regs_pkg::RW_BIT];
                addr_r <= ins_full[4:0];
                nbits_r <= reg_bits(ins_full[4:0]);
                rdw_r <= rd_word;
                sh_r <= 64'h0000000000000000;
                bcnt_r <= 7'h00;
                // Unmapped address: rest of frame ignored
                state_r <= (reg_bits(ins_full[4:0]) == 7'h00) ? S_DONE : S_DATA;
              end
            end
          end
          S_DATA:
          begin
            if (rise)
            begin
              sh_r <= sh_nxt;
              bcnt_r <= bcnt_r + 7'h01;
              if (last)
                state_r <= S_DONE;
            end
          end
          S_DONE:
            state_r <= S_DONE;
          default:
            state_r <= S_IDLE;
        endcase
      end
    end
  end

  // Read data changes on SCLK falling edge, ahead of host sampling
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_sdio <= 1'b0;
      o_sdio_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_cs_n || state_r != S_DATA || !rd_r)
        o_sdio_oe <= 1'b0;
      else if (fall)
      begin
        o_sdio_oe <= 1'b1;
        o_sdio <= pick(rdw_r, nbits_r, bcnt_r, lsb);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_r <= dds_regs_pkg::CTRL_RESET;
      o_phase_offset_six <= dds_regs_pkg::PHASE_RESET;
      o_tuning_word_six <= dds_regs_pkg::FTW_RESET;
      o_phase_offset_seven <= dds_regs_pkg::PHASE_RESET;
      o_tuning_word_seven <= dds_regs_pkg::FTW_RESET;
    end
    else if (i_ce && wr_commit)
    begin
      case (addr_r)
        // Reserved bits 17:16 stored as zero whatever the host sends
        dds_regs_pkg::ADDR_MAIN_CTRL: ctrl_r <= {wr_word[dds_regs_pkg::RAMP_RELOAD_BIT:dds_regs_pkg::HOLD_PHASE_BIT],
          2'h0, wr_word[dds_regs_pkg::LSB_FIRST_BIT]};
        dds_regs_pkg::ADDR_PROFILE_SIX:
        begin
          o_phase_offset_six <= wr_word[dds_regs_pkg::PHASE_LSB +: dds_regs_pkg::PHASE_W];
          o_tuning_word_six <= wr_word[dds_regs_pkg::FTW_W-1:0];
        end
        dds_regs_pkg::ADDR_PROFILE_SEVEN:
        begin
          o_phase_offset_seven <= wr_word[dds_regs_pkg::PHASE_LSB +: dds_regs_pkg::PHASE_W];
          o_tuning_word_seven <= wr_word[dds_regs_pkg::FTW_W-1:0];
        end
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Set wins over the readback clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      unlock_r <= 1'b0;
    else if (i_ce)
    begin
      if (i_lock_lost && i_sync_in_mode)
        unlock_r <= 1'b1;
      else if (rd_clear)
        unlock_r <= 1'b0;
    end
  end

  assign o_sine_sel = ctrl_r[dds_regs_pkg::SINE_BIT];
  assign o_lsb_first = ctrl_r[dds_regs_pkg::LSB_FIRST_BIT];
  assign ctl.update_pulse = upd_pulse_r;
  assign ctl.ramp_reload = ctrl_r[dds_regs_pkg::RAMP_RELOAD_BIT];
  assign ctl.autoclr_freq = ctrl_r[dds_regs_pkg::AUTOCLR_FREQ_BIT];
  assign ctl.autoclr_phase = ctrl_r[dds_regs_pkg::AUTOCLR_PHASE_BIT];
  assign ctl.hold_freq = ctrl_r[dds_regs_pkg::HOLD_FREQ_BIT];
  assign ctl.hold_phase = ctrl_r[dds_regs_pkg::HOLD_PHASE_BIT];

  dds_sync_core core (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .ctl(ctl.core),
    .i_sweep_en(i_sweep_en),
    .i_ramp_rate(i_ramp_rate),
    .i_sweep_delta(i_sweep_delta),
    .i_tuning_word_zero(i_tuning_word_zero),
    .o_freq_word(o_freq_word),
    .o_phase_acc(o_phase_acc)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ctrl_reset_a: assert property (@(posedge i_clk) disable iff (1'b0) i_rst |=> ctrl_r == 9'h000 && !unlock_r)
    else $error("control not reset to zero");
  unlock_set_a: assert property (i_ce && i_lock_lost && i_sync_in_mode |=> unlock_r)
    else $error("unlock flag not set");
  unlock_sticky_a: assert property (unlock_r && !(i_ce && rd_clear) |=> unlock_r)
    else $error("unlock flag dropped");
  unlock_clear_a: assert property (i_ce && rd_clear && !(i_lock_lost && i_sync_in_mode) |=> !unlock_r)
    else $error("unlock flag not cleared by readback");
  ctrl_write_a: assert property (i_ce && wr_commit && addr_r == dds_regs_pkg::ADDR_MAIN_CTRL
    |=> o_sine_sel == $past(wr_word[20]) && o_lsb_first == $past(wr_word[15]) && ctrl_r[17:16] == 2'h0)
    else $error("control write mismatch");
  profile_write_a: assert property (i_ce && wr_commit && addr_r == dds_regs_pkg::ADDR_PROFILE_SIX
    |=> o_tuning_word_six == $past(wr_word[47:0]) && o_phase_offset_six == $past(wr_word[61:48]))
    else $error("profile six write mismatch");
endmodule : dds_profile_and_control_regs

// ===== design/dds_regs_pkg.sv
package dds_regs_pkg;
  // Serial register addresses
  localparam logic [4:0] ADDR_MAIN_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PROFILE_SIX = 5'h0C;
  localparam logic [4:0] ADDR_PROFILE_SEVEN = 5'h0D;
  // Register lengths in serial bits
  localparam logic [6:0] CTRL_BITS = 7'h20;
  localparam logic [6:0] PROFILE_BITS = 7'h40;
  // Instruction byte layout
  localparam logic [2:0] INSTR_LAST = 3'h7;
  localparam int RW_BIT = 7;
  // Main control field positions
  localparam int UNLOCK_BIT = 24;
  localparam int RAMP_RELOAD_BIT = 23;
  localparam int AUTOCLR_FREQ_BIT = 22;
  localparam int AUTOCLR_PHASE_BIT = 21;
  localparam int SINE_BIT = 20;
  localparam int HOLD_FREQ_BIT = 19;
  localparam int HOLD_PHASE_BIT = 18;
  localparam int LSB_FIRST_BIT = 15;
  // Profile field layout
  localparam int PHASE_W = 14;
  localparam int FTW_W = 48;
  localparam int PHASE_LSB = 48;
  localparam int RAMP_W = 16;
  // Reset values
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [13:0] PHASE_RESET = 14'h0000;
  localparam logic [47:0] FTW_RESET = 48'h000000000000;
  // Sync clock is the system clock divided by four
  localparam int SYNC_DIV = 4;
  localparam logic [1:0] SYNC_LAST = 2'(SYNC_DIV - 1);
endpackage : dds_regs_pkg

// ===== design/dds_sync_core.sv
`timescale 1ns/1ps
module dds_sync_core (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Control from the register bank
  dds_ctrl_if.core ctl,
  // Sweep settings
  input wire logic i_sweep_en,
  input wire logic [15:0] i_ramp_rate,
  input wire logic [47:0] i_sweep_delta,
  input wire logic [47:0] i_tuning_word_zero,
  // Accumulator outputs
  output logic [47:0] o_freq_word,
  output logic [47:0] o_phase_acc
);
  logic [1:0] div_r;
  logic tick;
  logic pend_r;
  logic req;
  logic [15:0] ramp_cnt_r;
  logic step;
  logic [47:0] facc_r;
  logic [47:0] facc_nxt;

  assign tick = (div_r == dds_regs_pkg::SYNC_LAST);
  assign req = pend_r | ctl.update_pulse;
  assign step = i_sweep_en && (ramp_cnt_r == 16'h0000);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      div_r <= 2'h0;
    else if (i_ce)
      div_r <= div_r + 2'h1;
  end

  // Update strobe acts on the next sync edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pend_r <= 1'b0;
    else if (i_ce)
      pend_r <= tick ? 1'b0 : req;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ramp_cnt_r <= 16'h0000;
    else if (i_ce && tick)
    begin
      if (ramp_cnt_r == 16'h0000 || (req && ctl.ramp_reload && i_sweep_en))
        ramp_cnt_r <= i_ramp_rate;
      else
        ramp_cnt_r <= ramp_cnt_r - 16'h0001;
    end
  end

  always_comb
  begin
    if (ctl.hold_freq)
      facc_nxt = 48'h000000000000;
    else if (req && ctl.autoclr_freq)
      facc_nxt = 48'h000000000000;
    else if (step)
      facc_nxt = facc_r + i_sweep_delta;
    else
      facc_nxt = facc_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      facc_r <= 48'h000000000000;
      o_freq_word <= 48'h000000000000;
    end
    else if (i_ce && tick)
    begin
      facc_r <= facc_nxt;
      o_freq_word <= i_tuning_word_zero + facc_nxt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_phase_acc <= 48'h000000000000;
    else if (i_ce && tick)
    begin
      if (ctl.hold_phase || (req && ctl.autoclr_phase))
        o_phase_acc <= 48'h000000000000;
      else
        o_phase_acc <= o_phase_acc + o_freq_word;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_tick;
    tick && i_ce;
  endsequence

  sequence s_four_run;
    s_tick ##1 i_ce [*3];
  endsequence

  sync_gap_a: assert property (s_tick |=> !tick) else $error("sync tick repeated");
  sync_period_a: assert property (s_four_run |=> tick) else $error("sync period not four");
  freq_hold_a: assert property (s_tick and ctl.hold_freq |=> facc_r == 48'h000000000000)
    else $error("freq acc not held");
  phase_hold_a: assert property (s_tick and ctl.hold_phase |=> o_phase_acc == 48'h000000000000)
    else $error("phase acc not held");
  freq_clear_a: assert property (s_tick and (req && ctl.autoclr_freq)
    |=> facc_r == 48'h000000000000 && o_freq_word == $past(i_tuning_word_zero))
    else $error("freq autoclear failed");
  phase_clear_a: assert property (s_tick and (req && ctl.autoclr_phase) |=> o_phase_acc == 48'h000000000000)
    else $error("phase autoclear failed");
  ramp_load_a: assert property (s_tick and (ramp_cnt_r == 16'h0000) |=> ramp_cnt_r == $past(i_ramp_rate))
    else $error("ramp count not loaded");
  ramp_count_a: assert property (s_tick and (ramp_cnt_r != 16'h0000 && !(req && ctl.ramp_reload && i_sweep_en))
    |=> ramp_cnt_r == $past(ramp_cnt_r) - 16'h0001) else $error("ramp count not decremented");
  ramp_update_a: assert property (s_tick and (req && ctl.ramp_reload && i_sweep_en)
    |=> ramp_cnt_r == $past(i_ramp_rate)) else $error("ramp not reloaded by update");
endmodule : dds_sync_core

// ===== testbench/serial_host.sv
`timescale 1ns/1ps
module serial_host (
  // Clock
  input wire logic i_clk,
  // Serial lines toward the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdio,
  output logic o_sdio_oe,
  // Resolved data line
  input wire logic i_sdio
);
  logic lsb_mode;
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdio = 1'b0;
    o_sdio_oe = 1'b0;
    lsb_mode = 1'b0;
  end
  // One register per frame; nsend below nbits aborts the frame early
  task automatic xfer(input logic [7:0] instr, input logic [63:0] wdata, input int nbits, input int nsend,
                      output logic [63:0] rdata);
    int i;
    int k;
    logic rd;
    logic b;
    rd = instr[7];
    rdata = '0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    for (i = 0; i < 8 + nsend; i++)
    begin
      if (i < 8)
      begin
        k = lsb_mode ? i : 7 - i;
        b = instr[k];
      end
      else
      begin
        k = lsb_mode ? i - 8 : nbits - 1 - (i - 8);
        b = wdata[k];
      end
      // Data changes only while the serial clock is low; high and low phases two cycles each
      o_sclk <= 1'b0;
      o_sdio <= b;
      o_sdio_oe <= !(rd && i >= 8);
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
      if (rd && i >= 8)
        rdata[k] = i_sdio;
    end
    @(posedge i_clk);
    o_sclk <= 1'b0;
    o_sdio_oe <= 1'b0;
    o_cs_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : xfer
endmodule : serial_host

// ===== testbench/tb_dds_profile_and_control_regs.sv
`timescale 1ns/1ps
module tb_dds_profile_and_control_regs;
  logic clk = 1'b0, rst = 1'b1, cs_n, sclk, host_d, host_oe, dut_sdio, dut_oe, sdio_line, float_r = 1'b0;
  logic sync_in_mode = 1'b0, lock_lost = 1'b0, io_update = 1'b0, sweep_en = 1'b0, ce = 1'b1;
  logic [15:0] ramp_rate = 16'h0000;
  logic [47:0] sweep_delta = 48'h000000000000, tw0 = 48'h000000000000;
  logic sine_sel, lsb_first;
  logic [13:0] ph6, ph7;
  logic [47:0] tw6, tw7, freq_word, phase_acc;
  logic [63:0] d, r;
  int n_fail = 0, n_compared = 0, seed, i, g;
  logic seen;
  always #10 clk = ~clk;
  // Undriven line must not look like the last bit
  always @(posedge clk) float_r <= ~float_r;
  assign sdio_line = dut_oe ? dut_sdio : (host_oe ? host_d : float_r);
  serial_host serial_host_inst (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdio(host_d), .o_sdio_oe(host_oe),
    .i_sdio(sdio_line));
  dds_profile_and_control_regs dds_profile_and_control_regs_inst (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_sdio(sdio_line), .o_sdio(dut_sdio), .o_sdio_oe(dut_oe),
    .i_sync_in_mode(sync_in_mode), .i_lock_lost(lock_lost), .i_io_update(io_update), .i_sweep_en(sweep_en),
    .i_ramp_rate(ramp_rate), .i_sweep_delta(sweep_delta), .i_tuning_word_zero(tw0), .o_sine_sel(sine_sel),
    .o_lsb_first(lsb_first), .o_phase_offset_six(ph6), .o_tuning_word_six(tw6), .o_phase_offset_seven(ph7),
    .o_tuning_word_seven(tw7), .o_freq_word(freq_word), .o_phase_acc(phase_acc));
  task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : check
  task automatic stop_test();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  function automatic int bits_of(input logic [4:0] a);
    return (a == dds_regs_pkg::ADDR_MAIN_CTRL) ? 32 : 64;
  endfunction : bits_of
  // Only bits 24..18 and 15 of main control read back
  function automatic logic [63:0] ctrl_exp(input logic [31:0] w);
    return {32'h00000000, w & 32'h01FC8000};
  endfunction : ctrl_exp
  task automatic wr(input logic [4:0] a, input logic [63:0] v);
    serial_host_inst.xfer({3'h0, a}, v, bits_of(a), bits_of(a), r);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    serial_host_inst.xfer({3'h4, a}, 64'h0000000000000000, bits_of(a), bits_of(a), r);
  endtask : rd
  task automatic pulse_update();
    @(posedge clk);
    io_update <= 1'b1;
    repeat (2) @(posedge clk);
    io_update <= 1'b0;
  endtask : pulse_update
  // Cycles between two sweep steps; optional update strobe mid-step
  task automatic step_gap(input logic upd, output int gap);
    logic [47:0] p;
    gap = 0;
    p = freq_word;
    while (freq_word === p && gap < 400)
    begin
      @(posedge clk);
      gap++;
    end
    gap = 0;
    p = freq_word;
    if (upd)
    begin
      repeat (10) @(posedge clk);
      pulse_update();
      gap = 13;
    end
    while (freq_word === p && gap < 400)
    begin
      @(posedge clk);
      gap++;
    end
  endtask : step_gap
  task automatic watch_clear(input logic ph, output logic s);
    s = 1'b0;
    pulse_update();
    repeat (16)
    begin
      @(posedge clk);
      s = s | (ph ? (phase_acc === 48'h000000000000) : (freq_word === tw0));
    end
  endtask : watch_clear
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
  initial
  begin
    seed = 11;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({ph6, tw6}, 64'h0);
    check({ph7, tw7}, 64'h0);
    check({sine_sel, lsb_first}, 64'h0);
    check(freq_word, 64'h0);
    check(phase_acc, 64'h0);
    rd(dds_regs_pkg::ADDR_MAIN_CTRL);
    check(r, 64'h0);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      d = {$random(seed), $random(seed)} & 64'h3FFFFFFFFFFFFFFF;
      wr(i[0] ? dds_regs_pkg::ADDR_PROFILE_SEVEN : dds_regs_pkg::ADDR_PROFILE_SIX, d);
      check(i[0] ? {ph7, tw7} : {ph6, tw6}, d[61:0]);
      rd(i[0] ? dds_regs_pkg::ADDR_PROFILE_SEVEN : dds_regs_pkg::ADDR_PROFILE_SIX);
      check(r, d);
    end
    $display("test profiles done");
    for (i = 0; i < 3; i++)
    begin
      d = {32'h0, $random(seed)} & 64'h0000000000FC0000;
      wr(dds_regs_pkg::ADDR_MAIN_CTRL, d);
      check(sine_sel, d[20]);
      rd(dds_regs_pkg::ADDR_MAIN_CTRL);
      check(r, ctrl_exp(d[31:0]));
    end
    serial_host_inst.xfer(8'h00, d ^ 64'h100000, 32, 20, r);
    check(sine_sel, d[20]);
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h0);
    $display("test control done");
    sync_in_mode <= 1'b1;
    lock_lost <= 1'b1;
    @(posedge clk);
    lock_lost <= 1'b0;
    rd(dds_regs_pkg::ADDR_MAIN_CTRL);
    check(r, 64'h01000000);
    rd(dds_regs_pkg::ADDR_MAIN_CTRL);
    check(r, 64'h0);
    sync_in_mode <= 1'b0;
    lock_lost <= 1'b1;
    @(posedge clk);
    lock_lost <= 1'b0;
    rd(dds_regs_pkg::ADDR_MAIN_CTRL);
    check(r, 64'h0);
    $display("test unlock done");
    tw0 <= 48'({$random(seed), $random(seed)});
    sweep_delta <= 48'({$random(seed), $random(seed)} | 64'h1);
    sweep_en <= 1'b1;
    step_gap(1'b0, g);
    check(g, 4);
    // Enable low must freeze the sweep mid-run
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    d = {16'h0000, freq_word};
    repeat (8) @(posedge clk);
    check(freq_word, d[47:0]);
    ce <= 1'b1;
    ramp_rate <= 16'h0005;
    step_gap(1'b0, g);
    step_gap(1'b1, g);
    check(g, 24);
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h00800000);
    step_gap(1'b1, g);
    // Strobe acts on the fourth tick after a step: count restarts there
    check(g, 40);
    ramp_rate <= 16'h0000;
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h00400000);
    watch_clear(1'b0, seen);
    check(seen, 1'b1);
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h0);
    watch_clear(1'b0, seen);
    check(seen, 1'b0);
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h00200000);
    watch_clear(1'b1, seen);
    check(seen, 1'b1);
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h000C0000);
    repeat (10) @(posedge clk);
    check(freq_word, tw0);
    check(phase_acc, 48'h0);
    $display("test accumulators done");
    wr(dds_regs_pkg::ADDR_MAIN_CTRL, 64'h00008000);
    check(lsb_first, 1'b1);
    serial_host_inst.lsb_mode = 1'b1;
    d = {$random(seed), $random(seed)} & 64'h3FFFFFFFFFFFFFFF;
    wr(dds_regs_pkg::ADDR_PROFILE_SEVEN, d);
    check({ph7, tw7}, d[61:0]);
    rd(dds_regs_pkg::ADDR_PROFILE_SEVEN);
    check(r, d);
    $display("test bit order done");
    stop_test();
  end
endmodule : tb_dds_profile_and_control_regs
